// ==== rtl/crsc_pkg.sv ====
/*
 * Shared types and constants for the core ratio and stop-clock control.
 * Assumes a single 100 MHz bus clock domain; no other surroundings.
 */
package crsc_pkg;

  // ****************************************************************
  // Ratio strap codes, upper bit is the high select strap
  // ****************************************************************
  localparam logic [1:0] RATIO_CODE_1_3 = 2'h1;
  localparam logic [1:0] RATIO_CODE_2_5 = 2'h0;
  localparam logic [1:0] RATIO_CODE_1_2 = 2'h2;
  localparam logic [1:0] RATIO_CODE_2_3 = 2'h3;
  localparam logic [1:0] RATIO_CODE_RESET = 2'h3;

  // Numerator and denominator of the bus/core ratio
  localparam logic [2:0] RATIO_NUM_ONE = 3'h1;
  localparam logic [2:0] RATIO_NUM_TWO = 3'h2;
  localparam logic [2:0] RATIO_DEN_TWO = 3'h2;
  localparam logic [2:0] RATIO_DEN_THREE = 3'h3;
  localparam logic [2:0] RATIO_DEN_FIVE = 3'h5;

  // Clocks after reset release before the synced straps are valid
  localparam logic [1:0] STRAP_SETTLE_CNT = 2'h2;

  // Length of the stop-grant acknowledge bus cycle in bus-ready clocks
  localparam logic [1:0] ACK_CYCLE_LEN = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [2:0] num;
    logic [2:0] den;
  } crsc_ratio_s;

  typedef struct packed {
    logic valid;
    logic hit;
    logic hit_modified;
  } crsc_snoop_s;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_DRAIN,
    ST_IRQ,
    ST_ACK,
    ST_STOPPED
  } crsc_state_e;

endpackage : crsc_pkg

// ==== rtl/crsc_sync2.sv ====
/*
 * Two-flop synchroniser for one asynchronous level.
 * Assumes the destination clock is the bus clock.
 */
`timescale 1ns/10ps
module crsc_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_ff;
  logic sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : crsc_sync2

// ==== rtl/crsc_core_clock_ctrl.sv ====
/*
 * Core ratio capture and stop-clock sequencing for a processor core.
 * Assumes the halt request and ratio straps are asynchronous pins, while
 * the boundary, interrupt, bus and snoop signals are on the bus clock.
 */
`timescale 1ns/10ps

module crsc_core_clock_ctrl (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic core_halt_request_n_in,
  input wire logic ratio_select_hi_in,
  input wire logic ratio_select_lo_in,
  input wire logic insn_boundary_in,
  input wire logic irq_pending_in,
  input wire logic irq_taken_in,
  input wire logic bus_idle_in,
  input wire logic bus_ready_in,
  input wire crsc_pkg::crsc_snoop_s snoop_in,
  output logic core_clock_enable_out,
  output logic execute_enable_out,
  output logic ack_cycle_out,
  output logic stopped_out,
  output logic [1:0] ratio_code_out,
  output crsc_pkg::crsc_ratio_s ratio_out,
  output crsc_pkg::crsc_snoop_s snoop_out
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic halt_req_n_sync;
  logic ratio_hi_sync;
  logic ratio_lo_sync;

  crsc_sync2 #(.RESET_VAL(1'b1)) u_sync_halt (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .async_in(core_halt_request_n_in),
    .sync_out(halt_req_n_sync)
  );

  crsc_sync2 #(.RESET_VAL(1'b1)) u_sync_hi (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .async_in(ratio_select_hi_in),
    .sync_out(ratio_hi_sync)
  );

  crsc_sync2 #(.RESET_VAL(1'b1)) u_sync_lo (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .async_in(ratio_select_lo_in),
    .sync_out(ratio_lo_sync)
  );

  // ****************************************************************
  // Ratio strap capture
  // ****************************************************************
  // Capture waits for the synchroniser to fill after reset release, so
  // the straps must be stable for a few clocks around the release.
  logic [1:0] settle_ff;
  logic [1:0] nxt_settle;
  logic captured_ff;
  logic [1:0] ratio_code_ff;
  logic [1:0] nxt_ratio_code;
  logic capture_now;

  assign capture_now = !captured_ff &&
                       (settle_ff == crsc_pkg::STRAP_SETTLE_CNT);
  assign nxt_settle = capture_now ? settle_ff : settle_ff + 2'h1;
  assign nxt_ratio_code = capture_now ? {ratio_hi_sync, ratio_lo_sync}
                                      : ratio_code_ff;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      settle_ff <= 2'h0;
      captured_ff <= 1'b0;
      ratio_code_ff <= crsc_pkg::RATIO_CODE_RESET;
    end else begin
      settle_ff <= captured_ff ? settle_ff : nxt_settle;
      captured_ff <= captured_ff | capture_now;
      ratio_code_ff <= nxt_ratio_code;
    end
  end

  // Decode strap code into bus/core fraction; one driver per field wire
  logic [2:0] ratio_num;
  logic [2:0] ratio_den;
  crsc_pkg::crsc_ratio_s ratio_dec;
  assign ratio_num =
    (ratio_code_ff == crsc_pkg::RATIO_CODE_2_5 ||
     ratio_code_ff == crsc_pkg::RATIO_CODE_2_3) ?
    crsc_pkg::RATIO_NUM_TWO : crsc_pkg::RATIO_NUM_ONE;
  assign ratio_den =
    (ratio_code_ff == crsc_pkg::RATIO_CODE_1_3) ? crsc_pkg::RATIO_DEN_THREE :
    (ratio_code_ff == crsc_pkg::RATIO_CODE_2_5) ? crsc_pkg::RATIO_DEN_FIVE :
    (ratio_code_ff == crsc_pkg::RATIO_CODE_1_2) ? crsc_pkg::RATIO_DEN_TWO :
    crsc_pkg::RATIO_DEN_THREE;
  assign ratio_dec = '{num: ratio_num, den: ratio_den};

  crsc_pkg::crsc_ratio_s ratio_ff;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ratio_ff <= '0;
    end else begin
      ratio_ff <= ratio_dec;
    end
  end

  // ****************************************************************
  // Stop-clock sequencer
  // ****************************************************************
  crsc_pkg::crsc_state_e state_ff;
  crsc_pkg::crsc_state_e nxt_state;
  logic [1:0] ack_cnt_ff;
  logic [1:0] nxt_ack_cnt;
  logic halt_req;

  assign halt_req = !halt_req_n_sync;

  // Next state; interrupt service precedes the boundary stop
  always_comb begin
    nxt_state = state_ff;
    nxt_ack_cnt = ack_cnt_ff;
    case (state_ff)
      crsc_pkg::ST_RUN: begin
        if (halt_req) begin
          nxt_state = crsc_pkg::ST_DRAIN;
        end
      end
      crsc_pkg::ST_DRAIN: begin
        if (!halt_req) begin
          nxt_state = crsc_pkg::ST_RUN;
        end else if (irq_pending_in) begin
          nxt_state = crsc_pkg::ST_IRQ;
        end else if (insn_boundary_in && bus_idle_in) begin
          nxt_state = crsc_pkg::ST_ACK;
          nxt_ack_cnt = 2'h0;
        end
      end
      crsc_pkg::ST_IRQ: begin
        // Execution continues until the interrupt is entered
        if (irq_taken_in) begin
          nxt_state = crsc_pkg::ST_DRAIN;
        end
      end
      crsc_pkg::ST_ACK: begin
        // Acknowledge cycle held until the bus completes it
        if (bus_ready_in) begin
          nxt_ack_cnt = ack_cnt_ff + 2'h1;
          if (nxt_ack_cnt == crsc_pkg::ACK_CYCLE_LEN) begin
            nxt_state = crsc_pkg::ST_STOPPED;
          end
        end
      end
      crsc_pkg::ST_STOPPED: begin
        if (!halt_req) begin
          nxt_state = crsc_pkg::ST_RUN;
        end
      end
      default: begin
        nxt_state = crsc_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= crsc_pkg::ST_RUN;
      ack_cnt_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      ack_cnt_ff <= nxt_ack_cnt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic exec_en_ff;
  logic ack_ff;
  logic stopped_ff;
  logic clk_en_ff;

  // Registered status; core clock gated only once fully stopped
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      exec_en_ff <= 1'b1;
      ack_ff <= 1'b0;
      stopped_ff <= 1'b0;
      clk_en_ff <= 1'b1;
    end else begin
      exec_en_ff <= (nxt_state == crsc_pkg::ST_RUN) ||
                    (nxt_state == crsc_pkg::ST_DRAIN) ||
                    (nxt_state == crsc_pkg::ST_IRQ);
      ack_ff <= (nxt_state == crsc_pkg::ST_ACK);
      stopped_ff <= (nxt_state == crsc_pkg::ST_STOPPED);
      clk_en_ff <= (nxt_state != crsc_pkg::ST_STOPPED);
    end
  end

  // Snoop answers run on the bus clock, so they survive the core stop
  crsc_pkg::crsc_snoop_s snoop_ff;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      snoop_ff <= '0;
    end else begin
      snoop_ff <= snoop_in;
    end
  end

  assign core_clock_enable_out = clk_en_ff;
  assign execute_enable_out = exec_en_ff;
  assign ack_cycle_out = ack_ff;
  assign stopped_out = stopped_ff;
  assign ratio_code_out = ratio_code_ff;
  assign ratio_out = ratio_ff;
  assign snoop_out = snoop_ff;

endmodule : crsc_core_clock_ctrl

// ==== verification/crsc_chipset_model.sv ====
/* Far-side bus controller that answers the acknowledge cycle.
   Assumes one bus clock shared with the block. */
`timescale 1ns/10ps
module crsc_chipset_model (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic ack_cycle_in,
  input wire logic slow_in,
  output logic bus_ready_out
);
  logic tog_ff;
  // Toggle keeps ready from looking settled outside the cycle
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) tog_ff <= 1'b0;
    else tog_ff <= ~tog_ff;
  end
  // In the cycle, ready every clock, or every other clock when slow
  assign bus_ready_out = ack_cycle_in ? (!slow_in | tog_ff) : tog_ff;
endmodule : crsc_chipset_model

// ==== verification/crsc_core_clock_ctrl_monitor.sv ====
/* Checker for the ratio and stop-clock block.
   Bound to the top module; sees only its ports. */
`timescale 1ns/10ps
module crsc_core_clock_ctrl_monitor (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic insn_boundary_in,
  input wire logic irq_pending_in,
  input wire crsc_pkg::crsc_snoop_s snoop_in,
  input wire logic core_clock_enable_out,
  input wire logic execute_enable_out,
  input wire logic ack_cycle_out,
  input wire logic stopped_out,
  input wire logic [1:0] ratio_code_out,
  input wire crsc_pkg::crsc_ratio_s ratio_out,
  input wire crsc_pkg::crsc_snoop_s snoop_out
);
  logic [2:0] cnt_ff;
  logic [5:0] exp_ratio;
  // Fraction expected for the captured code
  assign exp_ratio = ratio_code_out == 2'h1 ? 6'h0B :
                     ratio_code_out == 2'h0 ? 6'h15 :
                     ratio_code_out == 2'h2 ? 6'h0A : 6'h13;
  // Edges since reset; early edges still show reset values
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) cnt_ff <= 3'h0;
    else if (cnt_ff != 3'h4) cnt_ff <= cnt_ff + 3'h1;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  a_clock_gate_ok: assert property (
    !core_clock_enable_out |-> stopped_out)
    else $error("core clock off while not stopped");
  a_boundary_stop: assert property ($rose(ack_cycle_out) |->
    !execute_enable_out && $past(insn_boundary_in && !irq_pending_in))
    else $error("ack began off boundary or with interrupt");
  a_ack_before_stop: assert property (
    $rose(stopped_out) |-> $past(ack_cycle_out))
    else $error("stopped without acknowledge cycle");
  a_ack_bounded: assert property (
    $rose(ack_cycle_out) |-> ##[1:40] stopped_out)
    else $error("acknowledge cycle never ended");
  a_snoop_served: assert property (snoop_out == $past(snoop_in))
    else $error("snoop result not passed on");
  a_ratio_decode: assert property (
    cnt_ff != 3'h0 |-> ratio_out == $past(exp_ratio))
    else $error("ratio does not match code");
  a_ratio_held: assert property (
    cnt_ff == 3'h4 |-> $stable(ratio_code_out))
    else $error("ratio code changed after capture");
endmodule : crsc_core_clock_ctrl_monitor
bind crsc_core_clock_ctrl crsc_core_clock_ctrl_monitor mon (
  .clock_in(clock_in),
  .reset_n_in(reset_n_in),
  .insn_boundary_in(insn_boundary_in),
  .irq_pending_in(irq_pending_in),
  .snoop_in(snoop_in),
  .core_clock_enable_out(core_clock_enable_out),
  .execute_enable_out(execute_enable_out),
  .ack_cycle_out(ack_cycle_out),
  .stopped_out(stopped_out),
  .ratio_code_out(ratio_code_out),
  .ratio_out(ratio_out),
  .snoop_out(snoop_out)
);

// ==== verification/crsc_core_clock_ctrl_tb.sv ====
/* Self-checking bench for the ratio and stop-clock block.
   Assumes the checker is bound and the chipset model is compiled. */
`timescale 1ns/10ps
module crsc_core_clock_ctrl_tb;
  logic clock_in = 1'b0, reset_n_in = 1'b0, halt_n = 1'b1, hi = 1'b1;
  logic lo = 1'b1, bnd = 1'b0, irqp = 1'b0, irqt = 1'b0, idle = 1'b1;
  logic slow = 1'b0, rdy, cke, exe, ack, stp, stp_d = 1'b0;
  logic [1:0] code;
  crsc_pkg::crsc_snoop_s snp = 3'h0, snp_d = 3'h0, sno;
  crsc_pkg::crsc_ratio_s rat;
  logic [5:0] rtab [4] = '{6'h15, 6'h0B, 6'h0A, 6'h13};
  logic [7:0] exp_q [$];
  int n_errors = 0, compares = 0, cyc = 0, rcnt = 0;
  always #5 clock_in = ~clock_in;
  crsc_core_clock_ctrl dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .core_halt_request_n_in(halt_n), .ratio_select_hi_in(hi),
    .ratio_select_lo_in(lo), .insn_boundary_in(bnd), .irq_pending_in(irqp),
    .irq_taken_in(irqt), .bus_idle_in(idle), .bus_ready_in(rdy),
    .snoop_in(snp), .core_clock_enable_out(cke), .execute_enable_out(exe),
    .ack_cycle_out(ack), .stopped_out(stp), .ratio_code_out(code),
    .ratio_out(rat), .snoop_out(sno));
  crsc_chipset_model chip (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .ack_cycle_in(ack), .slow_in(slow), .bus_ready_out(rdy));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  task summarize;
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  task tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask : tick
  // Watcher: counts ready clocks in the cycle, pops a note on each stop
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
    if (reset_n_in && ack && rdy) rcnt++;
    if (reset_n_in && stp && !stp_d) begin
      chk("ready_cnt", exp_q.pop_front(), 8'(rcnt));
      chk("run_off", 8'h0, {cke, exe});
      rcnt = 0;
    end
    if (reset_n_in) chk("snoop", snp_d, sno);
    snp_d = snp;
    stp_d = stp;
  end
  // Straps are changed after capture to prove they are ignored
  task do_reset(input logic [1:0] c);
    reset_n_in <= 1'b0;
    {hi, lo} <= c;
    tick(3);
    reset_n_in <= 1'b1;
    tick(6);
    chk("code", c, code);
    chk("ratio", rtab[c], rat);
    {hi, lo} <= 2'($urandom);
    tick(6);
    chk("code_held", c, code);
  endtask : do_reset
  // Stop waits for a boundary on an idle bus and for any pending interrupt to be taken
  task stop_seq(input logic s, input logic ip);
    slow <= s;
    irqp <= ip;
    bnd <= 1'b0;
    idle <= 1'b0;
    halt_n <= 1'b0;
    exp_q.push_back(8'h2);
    tick(8);
    chk("ack_wait", 8'h0, {ack, stp});
    bnd <= 1'b1;
    idle <= 1'b1;
    if (ip) begin
      tick(4);
      chk("ack_irq", 8'h1, {ack, stp, exe});
      irqt <= 1'b1;
      irqp <= 1'b0;
      tick(1);
      irqt <= 1'b0;
    end
    for (int i = 0; i < 60 && !stp; i++) begin
      tick(1);
      snp <= 3'($urandom);
    end
    repeat (4) begin
      tick(1);
      snp <= 3'($urandom);
    end
    chk("stopped", 8'h1, stp);
    snp <= 3'h0;
    halt_n <= 1'b1;
    bnd <= 1'b0;
    tick(8);
    chk("resumed", 8'h3, {cke, exe});
  endtask : stop_seq
  initial begin
    void'($urandom(46));
    // Reset spans these 17 clocks plus 3 inside the first do_reset
    tick(17);
    for (int c = 0; c < 4; c++) do_reset(2'(c));
    // A request withdrawn before any boundary must not reach the bus
    halt_n <= 1'b0;
    tick(6);
    chk("drain", 8'h0, {ack, stp});
    halt_n <= 1'b1;
    tick(8);
    bnd <= 1'b1;
    tick(6);
    chk("dropped", 8'hC, {cke, exe, ack, stp});
    bnd <= 1'b0;
    stop_seq(1'b0, 1'b0);
    stop_seq(1'b1, 1'b1);
    stop_seq(1'($urandom), 1'b0);
    tick(5);
    summarize();
  end
endmodule : crsc_core_clock_ctrl_tb
